// >>> divm_asserts.sv
// Port checker for the interrupt map block.
`timescale 1ns/1ps
module divm_asserts (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic sw_reset_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic int_ack_i,
	input wire logic int_req_o,
	input wire logic [4:0] int_trap_o,
	input wire logic [4:0] int_prio_o,
	input wire logic [15:0] int_vector_o,
	input wire logic reset_req_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	a_rsv_bits_zero: assert property (
		$past(reg_rd_i) && $past(reg_addr_i) < 4'h2 |-> reg_rdata_o[15:14] == 2'h0
	) else $error("reserved bit read back set");
	a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
		else $error("read data outside its cycle");
	a_reset_vec: assert property (
		reset_req_o |-> int_req_o && int_trap_o == 5'h00 && int_prio_o == 5'h01
		&& int_vector_o[6:0] == 7'h00) else $error("reset dispatch wrong");
	a_map_fixed: assert property (
		int_req_o && !reset_req_o |-> int_trap_o inside {[16:29]}
		&& int_prio_o == int_trap_o - 5'd13
		&& int_vector_o[6:0] == {int_trap_o, 2'b00}) else $error("bad trap map");
	a_vec_base: assert property (
		$past(reg_wr_i) && $past(reg_addr_i) == 4'h3
		|-> int_vector_o[15:7] == $past(reg_wdata_i[8:0])
	) else $error("vector base not applied");
	a_ack_reset: assert property (
		reset_req_o && int_ack_i && !sw_reset_i |=> !reset_req_o
	) else $error("reset not cleared by ack");
	a_swrst_take: assert property ($rose(sw_reset_i) |-> ##[1:6] reset_req_o)
		else $error("software reset not taken");
	a_mask_off: assert property (
		$past(reg_wr_i) && $past(reg_addr_i) == 4'h1 && $past(reg_wdata_i) == 16'h0
		&& !reset_req_o |-> !int_req_o) else $error("masked flag presented");
endmodule : divm_asserts
bind divm_top divm_asserts i_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
	.sw_reset_i(sw_reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.int_ack_i(int_ack_i), .int_req_o(int_req_o), .int_trap_o(int_trap_o),
	.int_prio_o(int_prio_o), .int_vector_o(int_vector_o),
	.reset_req_o(reset_req_o));

// >>> divm_core_model.sv
// Behavioural core that accepts dispatched interrupts and logs their traps.
`timescale 1ns/1ps
module divm_core_model (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic enable_i,
	input wire logic int_req_i,
	input wire logic [4:0] int_trap_i,
	output logic int_ack_o,
	output logic [39:0] log_o
);
	// Ack drops for a cycle after each take so the next winner can settle.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			int_ack_o <= 1'b0;
			log_o <= '0;
		end else begin
			int_ack_o <= enable_i && int_req_i && !int_ack_o;
			if (int_ack_o) begin
				log_o <= {log_o[34:0], int_trap_i};
			end
		end
	end
endmodule : divm_core_model

// >>> divm_pkg.sv
// Package of constants for the interrupt source map block.
package divm_pkg;

	// ------------------------------------------------------------
	// Register map on the plain register port
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFS_FLAGS = 4'h0;
	localparam logic [3:0] OFS_MASK = 4'h1;
	localparam logic [3:0] OFS_DMA_SEL = 4'h2;
	localparam logic [3:0] OFS_VEC_BASE = 4'h3;
	localparam logic [3:0] OFS_DISPATCH = 4'h4;
	localparam logic [3:0] OFS_ACK = 4'h5;

	// ------------------------------------------------------------
	// Flag and mask layout
	// ------------------------------------------------------------
	localparam int NSRC = 14;
	localparam logic [15:0] RESERVED_MASK = 16'hc000;
	localparam logic [15:0] FLAGS_RESET = 16'h0000;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic [3:0] DMA_SEL_RESET = 4'h0;
	localparam logic [8:0] VEC_BASE_RESET = 9'h1ff;

	localparam int BIT_EXT0 = 0;
	localparam int BIT_EXT1 = 1;
	localparam int BIT_EXT2 = 2;
	localparam int BIT_TMR_A = 3;
	localparam int BIT_SPA_RX = 4;
	localparam int BIT_SPA_TX = 5;
	localparam int BIT_SHR0 = 6;
	localparam int BIT_SHR1 = 7;
	localparam int BIT_EXT3 = 8;
	localparam int BIT_HOST = 9;
	localparam int BIT_SHR2 = 10;
	localparam int BIT_SHR3 = 11;
	localparam int BIT_DMA4 = 12;
	localparam int BIT_DMA5 = 13;

	// ------------------------------------------------------------
	// Trap numbers, vector offsets and priorities
	// ------------------------------------------------------------
	localparam logic [4:0] TRAP_RESET = 5'h00;
	localparam logic [6:0] VEC_RESET = 7'h00;
	localparam logic [4:0] PRIO_RESET = 5'h01;
	localparam logic [4:0] TRAP_FIRST = 5'h10;
	localparam logic [6:0] VEC_FIRST = 7'h40;
	localparam logic [4:0] PRIO_FIRST = 5'h03;

endpackage : divm_pkg

// >>> divm_top.sv
// Interrupt flag, mask and fixed priority dispatch for the core.
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// ------------------------------------------------------------
// ------------------------------------------------------------
module divm_top (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic sw_reset_i,
	input wire logic ext_pin_irq_0_i,
	input wire logic ext_pin_irq_1_i,
	input wire logic ext_pin_irq_2_i,
	input wire logic ext_pin_irq_3_i,
	input wire logic timer_a_irq_i,
	input wire logic timer_b_irq_i,
	input wire logic serial_port_a_rx_irq_i,
	input wire logic serial_port_a_tx_irq_i,
	input wire logic serial_port_b_rx_irq_i,
	input wire logic serial_port_b_tx_irq_i,
	input wire logic host_port_irq_i,
	input wire logic [5:0] dma_chan_irq_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	input wire logic int_ack_i,
	output logic int_req_o,
	output logic [4:0] int_trap_o,
	output logic [4:0] int_prio_o,
	output logic [15:0] int_vector_o,
	output logic reset_req_o
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// The external pins and the software reset are asynchronous; all other sources share the clock.
	logic [3:0] pin_meta;
	logic [3:0] pin_sync;
	logic [3:0] pin_prev;
	logic sw_meta;
	logic sw_sync;
	logic sw_prev;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pin_meta <= 4'h0;
			pin_sync <= 4'h0;
			pin_prev <= 4'h0;
			sw_meta <= 1'b0;
			sw_sync <= 1'b0;
			sw_prev <= 1'b0;
		end else begin
			pin_meta <= {ext_pin_irq_3_i, ext_pin_irq_2_i,
				ext_pin_irq_1_i, ext_pin_irq_0_i};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
			sw_meta <= sw_reset_i;
			sw_sync <= sw_meta;
			sw_prev <= sw_sync;
		end
	end

	// Pin requests are taken on the rising edge of the synchronised level.
	wire [3:0] pin_event = pin_sync & ~pin_prev;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [15:0] interrupt_pending_flags;
	logic [15:0] interrupt_enable_mask;
	logic [3:0] dma_priority_enable_control;
	logic [8:0] vec_base;
	logic [15:0] next_flags;
	logic reset_pend;

	// ------------------------------------------------------------
	// Source routing
	// ------------------------------------------------------------
	logic [15:0] src_event;
	always_comb begin
		src_event = 16'h0000;
		src_event[divm_pkg::BIT_EXT0] = pin_event[0];
		src_event[divm_pkg::BIT_EXT1] = pin_event[1];
		src_event[divm_pkg::BIT_EXT2] = pin_event[2];
		src_event[divm_pkg::BIT_TMR_A] = timer_a_irq_i;
		src_event[divm_pkg::BIT_SPA_RX] = serial_port_a_rx_irq_i;
		src_event[divm_pkg::BIT_SPA_TX] = serial_port_a_tx_irq_i;
		// Without the selection the bit has no source at all.
		src_event[divm_pkg::BIT_SHR0] = dma_priority_enable_control[0]
			& dma_chan_irq_i[0];
		src_event[divm_pkg::BIT_SHR1] = dma_priority_enable_control[1]
			? dma_chan_irq_i[1] : timer_b_irq_i;
		src_event[divm_pkg::BIT_EXT3] = pin_event[3];
		src_event[divm_pkg::BIT_HOST] = host_port_irq_i;
		src_event[divm_pkg::BIT_SHR2] = dma_priority_enable_control[2]
			? dma_chan_irq_i[2] : serial_port_b_rx_irq_i;
		src_event[divm_pkg::BIT_SHR3] = dma_priority_enable_control[3]
			? dma_chan_irq_i[3] : serial_port_b_tx_irq_i;
		src_event[divm_pkg::BIT_DMA4] = dma_chan_irq_i[4];
		src_event[divm_pkg::BIT_DMA5] = dma_chan_irq_i[5];
	end

	// ------------------------------------------------------------
	// Priority selection
	// ------------------------------------------------------------
	// Lowest bit wins because priority numbers rise with bit position.
	function automatic logic [3:0] lowest_set(input logic [15:0] v);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = divm_pkg::NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction : lowest_set

	// ------------------------------------------------------------
	// Per-source dispatch tables
	// ------------------------------------------------------------
	// The tables are spelled out rather than computed so that each source's
	// trap, priority and offset can be read next to its rule.
	function automatic logic [4:0] trap_of(input logic [3:0] idx);
		logic [4:0] t;
		case (idx)
			4'h0: t = 5'h10;
			4'h1: t = 5'h11;
			4'h2: t = 5'h12;
			4'h3: t = 5'h13;
			4'h4: t = 5'h14;
			4'h5: t = 5'h15;
			4'h6: t = 5'h16;
			4'h7: t = 5'h17;
			4'h8: t = 5'h18;
			4'h9: t = 5'h19;
			4'ha: t = 5'h1a;
			4'hb: t = 5'h1b;
			4'hc: t = 5'h1c;
			4'hd: t = 5'h1d;
			default: t = 5'h00;
		endcase
		return t;
	endfunction : trap_of

	function automatic logic [4:0] prio_of(input logic [3:0] idx);
		logic [4:0] p;
		case (idx)
			4'h0: p = 5'h03;
			4'h1: p = 5'h04;
			4'h2: p = 5'h05;
			4'h3: p = 5'h06;
			4'h4: p = 5'h07;
			4'h5: p = 5'h08;
			4'h6: p = 5'h09;
			4'h7: p = 5'h0a;
			4'h8: p = 5'h0b;
			4'h9: p = 5'h0c;
			4'ha: p = 5'h0d;
			4'hb: p = 5'h0e;
			4'hc: p = 5'h0f;
			4'hd: p = 5'h10;
			default: p = 5'h00;
		endcase
		return p;
	endfunction : prio_of

	function automatic logic [6:0] ofs_of(input logic [3:0] idx);
		logic [6:0] o;
		case (idx)
			4'h0: o = 7'h40;
			4'h1: o = 7'h44;
			4'h2: o = 7'h48;
			4'h3: o = 7'h4c;
			4'h4: o = 7'h50;
			4'h5: o = 7'h54;
			4'h6: o = 7'h58;
			4'h7: o = 7'h5c;
			4'h8: o = 7'h60;
			4'h9: o = 7'h64;
			4'ha: o = 7'h68;
			4'hb: o = 7'h6c;
			4'hc: o = 7'h70;
			4'hd: o = 7'h74;
			default: o = 7'h00;
		endcase
		return o;
	endfunction : ofs_of

	wire [15:0] live = interrupt_pending_flags & interrupt_enable_mask
		& ~divm_pkg::RESERVED_MASK;
	wire any_live = |live;
	wire [3:0] win_idx = lowest_set(live);
	wire [4:0] win_trap = trap_of(win_idx);
	wire [4:0] win_prio = prio_of(win_idx);
	wire [6:0] win_ofs = ofs_of(win_idx);
	wire [4:0] sel_trap = reset_pend ? divm_pkg::TRAP_RESET : win_trap;
	wire [4:0] sel_prio = reset_pend ? divm_pkg::PRIO_RESET : win_prio;
	wire [6:0] sel_ofs = reset_pend ? divm_pkg::VEC_RESET : win_ofs;
	wire [15:0] sel_vec = {vec_base, sel_ofs};
	wire [15:0] ack_clear = (int_ack_i && !reset_pend && any_live)
		? (16'h0001 << win_idx) : 16'h0000;

	// ------------------------------------------------------------
	// Register port decode
	// ------------------------------------------------------------
	wire wr_flags = reg_wr_i && reg_addr_i == divm_pkg::OFS_FLAGS;
	wire wr_mask = reg_wr_i && reg_addr_i == divm_pkg::OFS_MASK;
	wire wr_dma = reg_wr_i && reg_addr_i == divm_pkg::OFS_DMA_SEL;
	wire wr_base = reg_wr_i && reg_addr_i == divm_pkg::OFS_VEC_BASE;
	// Writing ones clears flags; a new event in the same cycle still sets.
	wire [15:0] sw_clear = wr_flags ? reg_wdata_i : 16'h0000;

	always_comb begin
		next_flags = (interrupt_pending_flags & ~sw_clear & ~ack_clear)
			| src_event;
		next_flags = next_flags & ~divm_pkg::RESERVED_MASK;
	end

	logic [15:0] rd_mux;
	always_comb begin
		case (reg_addr_i)
			divm_pkg::OFS_FLAGS: rd_mux = interrupt_pending_flags;
			divm_pkg::OFS_MASK: rd_mux = interrupt_enable_mask;
			divm_pkg::OFS_DMA_SEL: rd_mux = {12'h000,
				dma_priority_enable_control};
			divm_pkg::OFS_VEC_BASE: rd_mux = {7'h00, vec_base};
			divm_pkg::OFS_DISPATCH: rd_mux = {any_live || reset_pend,
				5'h00, sel_prio, sel_trap};
			default: rd_mux = 16'h0000;
		endcase
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			interrupt_pending_flags <= divm_pkg::FLAGS_RESET;
			interrupt_enable_mask <= divm_pkg::MASK_RESET;
			dma_priority_enable_control <= divm_pkg::DMA_SEL_RESET;
			vec_base <= divm_pkg::VEC_BASE_RESET;
			reset_pend <= 1'b1;
			reg_rdata_o <= 16'h0000;
		end else begin
			interrupt_pending_flags <= next_flags;
			if (wr_mask) begin
				interrupt_enable_mask <= reg_wdata_i
					& ~divm_pkg::RESERVED_MASK;
			end
			if (wr_dma) begin
				dma_priority_enable_control <= reg_wdata_i[3:0];
			end
			if (wr_base) begin
				vec_base <= reg_wdata_i[8:0];
			end
			if (sw_sync && !sw_prev) begin
				reset_pend <= 1'b1;
			end else if (int_ack_i) begin
				reset_pend <= 1'b0;
			end
			reg_rdata_o <= reg_rd_i ? rd_mux : 16'h0000;
		end
	end

	// ------------------------------------------------------------
	// Core request outputs
	// ------------------------------------------------------------
	// Reset outranks every maskable source and ignores the mask.
	assign int_req_o = reset_pend || any_live;
	assign int_trap_o = sel_trap;
	assign int_prio_o = sel_prio;
	assign int_vector_o = sel_vec;
	assign reset_req_o = reset_pend;

endmodule : divm_top

// >>> divm_top_tb_top.sv
// Self-checking bench for the interrupt map block.
`timescale 1ns/1ps
module divm_top_tb_top;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic sw_reset = 1'b0;
	logic core_en = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic [19:0] stim = 20'h00000;
	logic [15:0] rdata;
	logic [15:0] vec;
	logic [4:0] trap;
	logic [4:0] prio;
	logic req;
	logic ack;
	logic rstreq;
	logic [39:0] log_v;
	int err_total = 0;
	int compares = 0;
	int idx;
	// Row: DMA select, source stimulus, expected flags.
	logic [39:0] rows [19] = '{40'h0_00080_0080, 40'h0_04000_0000,
		40'h1_04000_0040, 40'h2_08000_0080, 40'h0_08000_0000, 40'h4_10000_0400,
		40'h0_00400_0400, 40'h8_20000_0800, 40'h0_00800_0800, 40'h0_40000_1000,
		40'h0_80000_2000, 40'h0_00008_0008, 40'h0_00010_0010, 40'h0_00020_0020,
		40'h0_00200_0200, 40'h0_00001_0001, 40'h0_00002_0002, 40'h0_00004_0004,
		40'h0_00100_0100};
	divm_top i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sw_reset_i(sw_reset),
		.ext_pin_irq_0_i(stim[0]), .ext_pin_irq_1_i(stim[1]),
		.ext_pin_irq_2_i(stim[2]), .ext_pin_irq_3_i(stim[8]),
		.timer_a_irq_i(stim[3]), .timer_b_irq_i(stim[7]),
		.serial_port_a_rx_irq_i(stim[4]), .serial_port_a_tx_irq_i(stim[5]),
		.serial_port_b_rx_irq_i(stim[10]), .serial_port_b_tx_irq_i(stim[11]),
		.host_port_irq_i(stim[9]), .dma_chan_irq_i(stim[19:14]),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .int_ack_i(ack), .int_req_o(req), .int_trap_o(trap),
		.int_prio_o(prio), .int_vector_o(vec), .reset_req_o(rstreq));
	divm_core_model i_core (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.enable_i(core_en), .int_req_i(req), .int_trap_i(trap), .int_ack_o(ack),
		.log_o(log_v));
	initial begin
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys_i);
		wr <= 1'b0;
		#1;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk_sys_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_sys_i);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask : rd_reg
	task automatic report_and_stop();
		if (err_total == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		#200000;
		err_total++;
		report_and_stop();
	end
	initial begin
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		#1 chk({rstreq, req, trap, prio}, 16'h0c01);
		chk(vec, 16'hff80);
		rd_reg(4'h4, 16'h8020);
		rd_reg(4'h0, 16'h0000);
		rd_reg(4'hf, 16'h0000);
		wr_reg(4'hf, 16'hffff);
		wr_reg(4'h1, 16'hffff);
		rd_reg(4'h1, 16'h3fff);
		rd_reg(4'h3, 16'h01ff);
		wr_reg(4'h3, 16'h0005);
		chk(vec, 16'h0280);
		wr_reg(4'h1, 16'h0000);
		@(posedge clk_sys_i);
		core_en <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		core_en <= 1'b0;
		#1 chk({rstreq, req, 9'h0, log_v[4:0]}, 16'h0000);
		foreach (rows[i]) begin
			wr_reg(4'h2, {12'h000, rows[i][39:36]});
			rd_reg(4'h2, {12'h000, rows[i][39:36]});
			@(posedge clk_sys_i);
			stim <= rows[i][35:16];
			repeat (5) @(posedge clk_sys_i);
			stim <= 20'h00000;
			repeat (5) @(posedge clk_sys_i);
			rd_reg(4'h0, rows[i][15:0]);
			chk({15'h0, req}, 16'h0000);
			wr_reg(4'h1, rows[i][15:0]);
			chk({15'h0, req}, {15'h0, rows[i][15:0] != 16'h0});
			for (int b = 0; b < 14; b++) if (rows[i][b]) idx = b;
			if (rows[i][15:0] != 16'h0) begin
				chk({trap, prio}, {6'h0, 5'(16 + idx), 5'(3 + idx)});
				chk(vec, {9'h005, 7'(64 + 4 * idx)});
				rd_reg(4'h4, {1'b1, 5'h00, 5'(3 + idx), 5'(16 + idx)});
			end
			wr_reg(4'h0, rows[i][15:0]);
			wr_reg(4'h1, 16'h0000);
			rd_reg(4'h0, 16'h0000);
		end
		wr_reg(4'h2, 16'h0000);
		wr_reg(4'h1, 16'h3fff);
		stim <= 20'h80218;
		@(posedge clk_sys_i);
		stim <= 20'h00000;
		core_en <= 1'b1;
		repeat (12) @(posedge clk_sys_i);
		core_en <= 1'b0;
		#1 chk({6'h0, log_v[19:10]}, {6'h0, 5'd19, 5'd20});
		chk({5'h0, req, log_v[9:0]}, {6'h0, 5'd25, 5'd29});
		@(posedge clk_sys_i);
		sw_reset <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		sw_reset <= 1'b0;
		#1 chk({15'h0, rstreq}, 16'h0001);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		#1 chk(vec, 16'hff80);
		report_and_stop();
	end
endmodule : divm_top_tb_top
